// *** hdl/ipb_priority_bank.sv ***
// interrupt priority bank, priority control registers 15..24 (19 absent)
// assumes an AXI4-Lite master on core_clk and arbitration logic downstream
//
// What this block does
// - code 111 is level seven, the highest user priority.
// - code 001 is level one; codes between map linearly.
// - code 000 disables the source; request masked regardless of flag.
// - unimplemented bits read zero and ignore writes.
// - every field resets to 100, level four.
// - register 21 usb field only exists when the usb module is present.
// - register 15 holds calendar, dma5, codec fields at 10-8, 6-4, 2-0.
// - register 16 holds checksum, serial2 error, serial1 error fields.
// - register 17 holds can2 tx, can1 tx, dma7, dma6 fields.
// - register 18 holds encoder2 and pwm secondary event; fault3 absent.
// - register 20 holds serial3 tx, rx and error fields.
// - register 21 holds serial4 error and usb fields only.
// - register 22 holds spi3, spi3 error, serial4 tx and rx fields.
// - register 23 holds pwm2, pwm1, capture9, compare9 fields.
// - register 24 holds pwm generators 6, 5, 4 and 3.
`timescale 1ns/1ps
`default_nettype none

module ipb_priority_bank
    import ipb_pkg::*;
#(
    // set when the device variant carries a usb module
    parameter bit HAS_USB = 1'b1
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // axi write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // priority fields toward arbitration
    output ipb_pkg::ipb_prio_type prioFields,
    // per-source request enables, low when the field is disabled
    output logic [28:0] sourceEnabled
);
    import ipb_pkg::*;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [15:0] ctrl15, ctrl16, ctrl17, ctrl18, ctrl20;
    logic [15:0] ctrl21, ctrl22, ctrl23, ctrl24;
    logic [15:0] usbMask;

    // ----------------------------------------------------------------
    // write channel
    // ----------------------------------------------------------------
    logic [7:0] awAddrHeld;
    logic awHeld;
    logic [31:0] wDataHeld;
    logic [3:0] wStrbHeld;
    logic wHeld;
    logic doWrite;
    logic [15:0] wLanes;
    logic wMapped;

    // usb field drops out of the mask without the module
    assign usbMask = HAS_USB ? IPB_MASK_CTRL21 : IPB_MASK_CTRL21_NOUSB;

    // accept each channel once, hold it until the write, take none again until the response is taken
    // no take while frozen, or the master would lose its request
    assign s_axi_awready = clkEn && !awHeld && !s_axi_bvalid;
    assign s_axi_wready = clkEn && !wHeld && !s_axi_bvalid;
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;

    // capture write address
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            awAddrHeld <= 8'h00;
        end else if (clkEn) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddrHeld <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
        end
    end

    // capture write data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wHeld <= 1'b0;
            wDataHeld <= 32'h0000_0000;
            wStrbHeld <= 4'h0;
        end else if (clkEn) begin
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wDataHeld <= s_axi_wdata;
                wStrbHeld <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    // byte-lane merge: lanes without a strobe keep the old value later
    assign wLanes = wDataHeld[15:0];

    // masked merge of a write into one register
    function automatic logic [15:0] mergeWrite(
        input logic [15:0] oldVal,
        input logic [15:0] newVal,
        input logic [3:0] strb,
        input logic [15:0] mask
    );
        logic [15:0] laneMask;
        laneMask = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        // bits outside the mask never change
        return (oldVal & ~laneMask) | (newVal & laneMask);
    endfunction : mergeWrite

    // address decode for the write side
    always_comb begin
        wMapped = 1'b1;
        if (awAddrHeld == IPB_OFS_CTRL15) begin
            wMapped = 1'b1;
        end else if (awAddrHeld == IPB_OFS_CTRL16) begin
            wMapped = 1'b1;
        end else if (awAddrHeld == IPB_OFS_CTRL17) begin
            wMapped = 1'b1;
        end else if (awAddrHeld == IPB_OFS_CTRL18) begin
            wMapped = 1'b1;
        end else if (awAddrHeld == IPB_OFS_CTRL20) begin
            wMapped = 1'b1;
        end else if (awAddrHeld == IPB_OFS_CTRL21) begin
            wMapped = 1'b1;
        end else if (awAddrHeld == IPB_OFS_CTRL22) begin
            wMapped = 1'b1;
        end else if (awAddrHeld == IPB_OFS_CTRL23) begin
            wMapped = 1'b1;
        end else if (awAddrHeld == IPB_OFS_CTRL24) begin
            wMapped = 1'b1;
        end else begin
            wMapped = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    // reset all fields to 100; new value visible next cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl15 <= IPB_RESET_PATTERN & IPB_MASK_CTRL15;
            ctrl16 <= IPB_RESET_PATTERN & IPB_MASK_CTRL16;
            ctrl17 <= IPB_RESET_PATTERN & IPB_MASK_FULL;
            ctrl18 <= IPB_RESET_PATTERN & IPB_MASK_CTRL18;
            ctrl20 <= IPB_RESET_PATTERN & IPB_MASK_CTRL16;
            ctrl21 <= IPB_RESET_PATTERN & IPB_MASK_CTRL21;
            ctrl22 <= IPB_RESET_PATTERN & IPB_MASK_FULL;
            ctrl23 <= IPB_RESET_PATTERN & IPB_MASK_FULL;
            ctrl24 <= IPB_RESET_PATTERN & IPB_MASK_FULL;
        end else if (clkEn && doWrite) begin
            if (awAddrHeld == IPB_OFS_CTRL15) begin
                ctrl15 <= mergeWrite(ctrl15, wLanes, wStrbHeld, IPB_MASK_CTRL15);
            end else if (awAddrHeld == IPB_OFS_CTRL16) begin
                ctrl16 <= mergeWrite(ctrl16, wLanes, wStrbHeld, IPB_MASK_CTRL16);
            end else if (awAddrHeld == IPB_OFS_CTRL17) begin
                ctrl17 <= mergeWrite(ctrl17, wLanes, wStrbHeld, IPB_MASK_FULL);
            // register 18, fault3 bits kept unimplemented
            end else if (awAddrHeld == IPB_OFS_CTRL18) begin
                ctrl18 <= mergeWrite(ctrl18, wLanes, wStrbHeld, IPB_MASK_CTRL18);
            end else if (awAddrHeld == IPB_OFS_CTRL20) begin
                ctrl20 <= mergeWrite(ctrl20, wLanes, wStrbHeld, IPB_MASK_CTRL16);
            end else if (awAddrHeld == IPB_OFS_CTRL21) begin
                ctrl21 <= mergeWrite(ctrl21, wLanes, wStrbHeld, usbMask);
            end else if (awAddrHeld == IPB_OFS_CTRL22) begin
                ctrl22 <= mergeWrite(ctrl22, wLanes, wStrbHeld, IPB_MASK_FULL);
            end else if (awAddrHeld == IPB_OFS_CTRL23) begin
                ctrl23 <= mergeWrite(ctrl23, wLanes, wStrbHeld, IPB_MASK_FULL);
            end else if (awAddrHeld == IPB_OFS_CTRL24) begin
                ctrl24 <= mergeWrite(ctrl24, wLanes, wStrbHeld, IPB_MASK_FULL);
            end
        end
    end

    // write response, okay or slverr for unmapped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= IPB_RESP_OKAY;
        end else if (clkEn) begin
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wMapped ? IPB_RESP_OKAY : IPB_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    logic [15:0] readWord;
    logic readMapped;

    // decode, unimplemented bits read zero: stored zero, or masked for the absent usb field
    always_comb begin
        readWord = 16'h0000;
        readMapped = 1'b1;
        if (s_axi_araddr == IPB_OFS_CTRL15) begin
            readWord = ctrl15;
        end else if (s_axi_araddr == IPB_OFS_CTRL16) begin
            readWord = ctrl16;
        end else if (s_axi_araddr == IPB_OFS_CTRL17) begin
            readWord = ctrl17;
        end else if (s_axi_araddr == IPB_OFS_CTRL18) begin
            readWord = ctrl18;
        end else if (s_axi_araddr == IPB_OFS_CTRL20) begin
            readWord = ctrl20;
        end else if (s_axi_araddr == IPB_OFS_CTRL21) begin
            // usb bits read zero when absent
            readWord = ctrl21 & usbMask;
        end else if (s_axi_araddr == IPB_OFS_CTRL22) begin
            readWord = ctrl22;
        end else if (s_axi_araddr == IPB_OFS_CTRL23) begin
            readWord = ctrl23;
        end else if (s_axi_araddr == IPB_OFS_CTRL24) begin
            readWord = ctrl24;
        end else begin
            readMapped = 1'b0;
        end
    end

    // one read in flight; ready only while no data is pending
    assign s_axi_arready = clkEn && !s_axi_rvalid;

    // read data register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= IPB_RESP_OKAY;
        end else if (clkEn) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {16'h0000, readWord};
                s_axi_rresp <= readMapped ? IPB_RESP_OKAY : IPB_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // arbitration view
    // ----------------------------------------------------------------
    logic [15:0] ctrl21Live;
    assign ctrl21Live = ctrl21 & usbMask;

    // fields presented straight from the registers, register 21 through usbMask
    assign prioFields = '{
        calendar_clock_prio: ctrl15[IPB_POS_F2 +: 3],
        dma_ch5_done_prio: ctrl15[IPB_POS_F1 +: 3],
        codec_iface_event_prio: ctrl15[IPB_POS_F0 +: 3],
        checksum_gen_prio: ctrl16[IPB_POS_F3 +: 3],
        serial2_error_prio: ctrl16[IPB_POS_F2 +: 3],
        serial1_error_prio: ctrl16[IPB_POS_F1 +: 3],
        can2_tx_request_prio: ctrl17[IPB_POS_F3 +: 3],
        can1_tx_request_prio: ctrl17[IPB_POS_F2 +: 3],
        dma_ch7_done_prio: ctrl17[IPB_POS_F1 +: 3],
        dma_ch6_done_prio: ctrl17[IPB_POS_F0 +: 3],
        quad_encoder2_prio: ctrl18[IPB_POS_F3 +: 3],
        pwm_secondary_event_prio: ctrl18[IPB_POS_F1 +: 3],
        serial3_tx_prio: ctrl20[IPB_POS_F3 +: 3],
        serial3_rx_prio: ctrl20[IPB_POS_F2 +: 3],
        serial3_error_prio: ctrl20[IPB_POS_F1 +: 3],
        serial4_error_prio: ctrl21Live[IPB_POS_F3 +: 3],
        usb_event_prio: ctrl21Live[IPB_POS_F2 +: 3],
        spi_port3_prio: ctrl22[IPB_POS_F3 +: 3],
        spi_port3_error_prio: ctrl22[IPB_POS_F2 +: 3],
        serial4_tx_prio: ctrl22[IPB_POS_F1 +: 3],
        serial4_rx_prio: ctrl22[IPB_POS_F0 +: 3],
        pwm_gen2_prio: ctrl23[IPB_POS_F3 +: 3],
        pwm_gen1_prio: ctrl23[IPB_POS_F2 +: 3],
        capture9_prio: ctrl23[IPB_POS_F1 +: 3],
        compare9_prio: ctrl23[IPB_POS_F0 +: 3],
        pwm_gen6_prio: ctrl24[IPB_POS_F3 +: 3],
        pwm_gen5_prio: ctrl24[IPB_POS_F2 +: 3],
        pwm_gen4_prio: ctrl24[IPB_POS_F1 +: 3],
        pwm_gen3_prio: ctrl24[IPB_POS_F0 +: 3]
    };

    // level equals code; zero code blocks the source
    always_comb begin
        logic [86:0] flat;
        flat = prioFields;
        for (int i = 0; i < 29; i++) begin
            sourceEnabled[i] = (flat[3*i +: 3] != IPB_PRIO_OFF);
        end
    end

endmodule : ipb_priority_bank
`default_nettype wire

// *** include/ipb_pkg.sv ***
// package for the interrupt priority bank, registers 15 to 24
// assumes one core clock domain and an AXI4-Lite register slave
package ipb_pkg;

    // ----------------------------------------------------------------
    // register byte offsets (nine implemented words)
    // ----------------------------------------------------------------
    localparam logic [7:0] IPB_OFS_CTRL15 = 8'h00;
    localparam logic [7:0] IPB_OFS_CTRL16 = 8'h04;
    localparam logic [7:0] IPB_OFS_CTRL17 = 8'h08;
    localparam logic [7:0] IPB_OFS_CTRL18 = 8'h0C;
    localparam logic [7:0] IPB_OFS_CTRL20 = 8'h10;
    localparam logic [7:0] IPB_OFS_CTRL21 = 8'h14;
    localparam logic [7:0] IPB_OFS_CTRL22 = 8'h18;
    localparam logic [7:0] IPB_OFS_CTRL23 = 8'h1C;
    localparam logic [7:0] IPB_OFS_CTRL24 = 8'h20;

    // ----------------------------------------------------------------
    // writable-bit masks: a set bit holds a priority field
    // ----------------------------------------------------------------
    localparam logic [15:0] IPB_MASK_CTRL15 = 16'h0777;
    localparam logic [15:0] IPB_MASK_CTRL16 = 16'h7770;
    localparam logic [15:0] IPB_MASK_FULL = 16'h7777;
    localparam logic [15:0] IPB_MASK_CTRL18 = 16'h7070;
    localparam logic [15:0] IPB_MASK_CTRL21 = 16'h7700;
    localparam logic [15:0] IPB_MASK_CTRL21_NOUSB = 16'h7000;

    // ----------------------------------------------------------------
    // field positions and reset value
    // ----------------------------------------------------------------
    localparam int IPB_POS_F3 = 12;
    localparam int IPB_POS_F2 = 8;
    localparam int IPB_POS_F1 = 4;
    localparam int IPB_POS_F0 = 0;
    localparam logic [15:0] IPB_RESET_PATTERN = 16'h4444;
    localparam logic [2:0] IPB_PRIO_OFF = 3'h0;

    // axi response codes
    localparam logic [1:0] IPB_RESP_OKAY = 2'h0;
    localparam logic [1:0] IPB_RESP_SLVERR = 2'h2;

    // priority outputs grouped per register
    typedef struct packed {
        logic [2:0] calendar_clock_prio;
        logic [2:0] dma_ch5_done_prio;
        logic [2:0] codec_iface_event_prio;
        logic [2:0] checksum_gen_prio;
        logic [2:0] serial2_error_prio;
        logic [2:0] serial1_error_prio;
        logic [2:0] can2_tx_request_prio;
        logic [2:0] can1_tx_request_prio;
        logic [2:0] dma_ch7_done_prio;
        logic [2:0] dma_ch6_done_prio;
        logic [2:0] quad_encoder2_prio;
        logic [2:0] pwm_secondary_event_prio;
        logic [2:0] serial3_tx_prio;
        logic [2:0] serial3_rx_prio;
        logic [2:0] serial3_error_prio;
        logic [2:0] serial4_error_prio;
        logic [2:0] usb_event_prio;
        logic [2:0] spi_port3_prio;
        logic [2:0] spi_port3_error_prio;
        logic [2:0] serial4_tx_prio;
        logic [2:0] serial4_rx_prio;
        logic [2:0] pwm_gen2_prio;
        logic [2:0] pwm_gen1_prio;
        logic [2:0] capture9_prio;
        logic [2:0] compare9_prio;
        logic [2:0] pwm_gen6_prio;
        logic [2:0] pwm_gen5_prio;
        logic [2:0] pwm_gen4_prio;
        logic [2:0] pwm_gen3_prio;
    } ipb_prio_type;

endpackage : ipb_pkg

// *** verification/ipb_priority_bank_asserts.sv ***
// concurrent checks on the priority bank ports
// assumes bind onto ipb_priority_bank with the usb field present
`timescale 1ns/1ps
`default_nettype none

module ipb_priority_bank_asserts
    import ipb_pkg::*;
(
    // clock and control
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // axi write side
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi read side
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // arbitration side
    input wire ipb_pkg::ipb_prio_type prioFields,
    input wire logic [28:0] sourceEnabled
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // helpers: last read address, expected enables
    // ----------------------------------------------------------------
    logic [7:0] rdAddr;
    logic [28:0] enCalc;
    logic [15:0] rdMask;
    logic bothTaken;

    // address of the read now being answered
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdAddr <= 8'h00;
        end else if (clkEn && s_axi_arvalid && s_axi_arready) begin
            rdAddr <= s_axi_araddr;
        end
    end

    // a zero code blocks its source, anything else lets it through
    always_comb begin
        for (int i = 0; i < 29; i++) begin
            enCalc[i] = |prioFields[3*i +: 3];
        end
        case (rdAddr)
            8'h00: rdMask = 16'h0777;
            8'h04, 8'h10: rdMask = 16'h7770;
            8'h0C: rdMask = 16'h7070;
            8'h14: rdMask = 16'h7700;
            default: rdMask = 16'h7777;
        endcase
    end
    assign bothTaken = clkEn && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_src_enable: assert property (sourceEnabled == enCalc)
        else $error("source enable disagrees with field code");
    a_unimpl_zero: assert property (s_axi_rvalid && s_axi_rresp == IPB_RESP_OKAY |->
        (s_axi_rdata & ~{16'h0000, rdMask}) == 32'h0000_0000)
        else $error("unimplemented read bit is set");
    a_unmapped_err: assert property (clkEn && s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > 8'h20 |=> s_axi_rvalid && s_axi_rresp == IPB_RESP_SLVERR)
        else $error("unmapped read not refused");
    a_reset_default: assert property ($rose(rst_n) |-> prioFields == {29{3'h4}})
        else $error("field not at default after reset");
    a_pwm3_lands: assert property (bothTaken && s_axi_awaddr == IPB_OFS_CTRL24 &&
        s_axi_wstrb[0] |=> ##1 prioFields.pwm_gen3_prio == $past(s_axi_wdata[2:0], 2))
        else $error("written code not presented next cycle");
    a_usb_lands: assert property (bothTaken && s_axi_awaddr == IPB_OFS_CTRL21 &&
        s_axi_wstrb[1] |=> ##1 prioFields.usb_event_prio == $past(s_axi_wdata[10:8], 2))
        else $error("usb field not written");
    a_change_on_write: assert property (!$stable(prioFields) |-> $rose(s_axi_bvalid))
        else $error("field moved without a write");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_read_next: assert property (clkEn && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule : ipb_priority_bank_asserts

bind ipb_priority_bank ipb_priority_bank_asserts i_ipb_priority_bank_asserts (
    .core_clk, .rst_n, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .prioFields, .sourceEnabled
);

`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the priority bank over axi4-lite
// assumes the usb field is present and clkEn held high
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import ipb_pkg::*;
    logic core_clk, rst_n, clkEn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    ipb_prio_type prioFields;
    logic [28:0] sourceEnabled;
    int n_fail = 0;
    int checks = 0;
    logic [7:0] regAddr [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};

    ipb_priority_bank #(.HAS_USB(1'b1)) i_ipb_priority_bank (.*);

    // 250 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // compare and report
    // ----------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_word({30'h0, got}, {30'h0, exp});
    endtask : chk_resp

    task automatic chk_prio(input ipb_prio_type got, input ipb_prio_type exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_prio

    task automatic give_verdict();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // whole run needs well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        give_verdict();
    end

    // ----------------------------------------------------------------
    // bus cycles
    // ----------------------------------------------------------------
    // field bits per word; everything else reads zero
    function automatic logic [15:0] mask_of(input logic [7:0] a);
        case (a)
            IPB_OFS_CTRL15: return IPB_MASK_CTRL15;
            IPB_OFS_CTRL16, IPB_OFS_CTRL20: return IPB_MASK_CTRL16;
            IPB_OFS_CTRL18: return IPB_MASK_CTRL18;
            IPB_OFS_CTRL21: return IPB_MASK_CTRL21;
            default: return IPB_MASK_FULL;
        endcase
    endfunction : mask_of

    // address and data offered together, each dropped when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 64);
        if (!s_axi_bvalid) n_fail++;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 64);
        if (!s_axi_rvalid) n_fail++;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] r;
        axi_write(a, d, s, r);
        chk_resp(r, IPB_RESP_OKAY);
    endtask : wr_ok

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        chk_word(d, exp);
        chk_resp(r, IPB_RESP_OKAY);
    endtask : rd_chk

    task automatic chk_all_reset();
        for (int i = 0; i < 9; i++) begin
            rd_chk(regAddr[i], {16'h0, mask_of(regAddr[i]) & IPB_RESET_PATTERN});
        end
        chk_word({3'h0, sourceEnabled}, 32'h1FFF_FFFF);
    endtask : chk_all_reset

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        ipb_prio_type expPrio;
        {clkEn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        clkEn = 1'b1;
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        chk_all_reset();
        // all ones: only field bits stick
        for (int i = 0; i < 9; i++) begin
            wr_ok(regAddr[i], 32'hFFFF_FFFF, 4'hF);
            rd_chk(regAddr[i], {16'h0, mask_of(regAddr[i])});
        end
        chk_word({3'h0, sourceEnabled}, 32'h1FFF_FFFF);
        // all zero: every source blocked
        for (int i = 0; i < 9; i++) begin
            wr_ok(regAddr[i], 32'h0000_0000, 4'hF);
        end
        chk_word({3'h0, sourceEnabled}, 32'h0000_0000);
        // every code on the four generator fields
        for (int i = 0; i < 8; i++) begin
            wr_ok(IPB_OFS_CTRL24, {16'h0, {4{1'b0, i[2:0]}}}, 4'hF);
            chk_word({29'h0, prioFields.pwm_gen3_prio}, i);
            chk_word({31'h0, sourceEnabled[0]}, {31'h0, i != 0});
        end
        // byte strobes merge into the old value
        wr_ok(IPB_OFS_CTRL23, 32'hFFFF_1111, 4'h1);
        rd_chk(IPB_OFS_CTRL23, 32'h0000_0011);
        wr_ok(IPB_OFS_CTRL23, 32'h0000_2222, 4'h2);
        rd_chk(IPB_OFS_CTRL23, 32'h0000_2211);
        // distinct codes show where each field lands
        wr_ok(IPB_OFS_CTRL15, 32'h0000_0123, 4'hF);
        wr_ok(IPB_OFS_CTRL16, 32'h0000_5670, 4'hF);
        wr_ok(IPB_OFS_CTRL17, 32'h0000_1234, 4'hF);
        wr_ok(IPB_OFS_CTRL18, 32'h0000_6720, 4'hF);
        wr_ok(IPB_OFS_CTRL20, 32'h0000_1230, 4'hF);
        wr_ok(IPB_OFS_CTRL21, 32'h0000_3500, 4'hF);
        wr_ok(IPB_OFS_CTRL22, 32'h0000_7654, 4'hF);
        expPrio = {3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h2,
                   3'h1, 3'h2, 3'h3, 3'h3, 3'h5, 3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h2, 3'h1,
                   3'h1, 3'h7, 3'h7, 3'h7, 3'h7};
        chk_prio(prioFields, expPrio);
        rd_chk(IPB_OFS_CTRL18, 32'h0000_6020);
        // unmapped places refuse and change nothing
        axi_write(8'h24, 32'hFFFF_FFFF, 4'hF, r);
        chk_resp(r, IPB_RESP_SLVERR);
        axi_read(8'hFC, d, r);
        chk_word(d, 32'h0000_0000);
        chk_resp(r, IPB_RESP_SLVERR);
        chk_prio(prioFields, expPrio);
        // second reset in mid-run
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        chk_all_reset();
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
